// ==== brd_pkg.sv ====
// Package: address map, slave codes and carrier structs for the boot decoder
package brd_pkg;

  localparam int ADDR_W = 32;
  localparam int EXT_ADDR_W = 26;
  localparam int MASTER_N = 6;

  // Edges after release that pass before the synchronised boot pin is taken on the next edge
  localparam logic [1:0] PIN_CAP_CNT = 2'h2;

  // Top-level bank split: 16 banks of 256 Mbytes
  localparam int BANK_MSB = 31;
  localparam int BANK_LSB = 28;
  localparam logic [3:0] BANK_INTERNAL = 4'h0;
  localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
  localparam logic [3:0] BANK_EXT_LAST = 4'h8;
  localparam logic [3:0] BANK_PERIPH = 4'hF;

  // Second level inside the internal bank: 1 Mbyte areas
  localparam int AREA_MSB = 27;
  localparam int AREA_LSB = 20;
  localparam logic [7:0] AREA_BOOT = 8'h00;
  localparam logic [7:0] AREA_ROM = 8'h01;
  localparam logic [7:0] AREA_FIRST_INTERNAL_SRAM = 8'h02;
  localparam logic [7:0] AREA_SECOND_INTERNAL_SRAM = 8'h03;
  localparam logic [7:0] AREA_USBH = 8'h05;

  // Masters that see the three-way boot region
  localparam int CPU_INSN = 0;
  localparam int CPU_DATA = 1;

  // External chip select roles
  localparam logic [2:0] CS_ZERO = 3'h0;
  localparam logic [2:0] CS_ONE = 3'h1;
  localparam logic [2:0] CS_THREE = 3'h3;
  localparam logic [2:0] CS_FOUR = 3'h4;
  localparam logic [2:0] CS_FIVE = 3'h5;

  // Static controller reset defaults for external boot
  localparam logic [1:0] DBW_16 = 2'h1;

  typedef enum logic [2:0] {
    SLV_ROM   = 3'h0,
    SLV_FIRST_INTERNAL_SRAM = 3'h1,
    SLV_SECOND_INTERNAL_SRAM = 3'h2,
    SLV_USBH  = 3'h3,
    SLV_EXT   = 3'h4,
    SLV_PERIPH = 3'h5,
    SLV_ABORT = 3'h6
  } brd_slave_e;

  typedef enum logic [1:0] {
    CSC_STATIC = 2'h0,
    CSC_SDRAM  = 2'h1,
    CSC_NAND   = 2'h2,
    CSC_CARD   = 2'h3
  } brd_csctl_e;

  typedef struct packed {
    logic             valid;
    logic [ADDR_W-1:0] addr;
  } brd_req_s;

  typedef struct packed {
    logic                  valid;
    brd_slave_e            slave;
    logic [ADDR_W-1:0]     local_addr;
    logic [2:0]            cs;
    brd_csctl_e            csctl;
    logic [EXT_ADDR_W-1:0] ext_addr;
    logic                  abort;
  } brd_sel_s;

  typedef struct packed {
    logic       byte_select;
    logic [1:0] data_width;
    logic       strobe_by_cs;
  } brd_smc_cfg_s;

endpackage

// ==== brd_decoder.sv ====
// Boot remap address decoder: one independent decoder per bus master
`timescale 1ns/1ps
`default_nettype none

// Function
// - Fetch starts at address zero after reset
// - Remap set puts first SRAM at zero
// - Remap clear, pin high: ROM at zero
// - Remap clear, pin low: chip select zero
// - Boot pin captured at reset, held
// - Boot region spans first megabyte only
// - ROM, SRAMs, USB host always visible
// - CPU masters get three boot slaves
// - Each master has own decoder
// - Each chip select gets 256 Mbytes
// - External boot: byte select, 16-bit, CS strobes
// - Chip select one: SDRAM or static
// - Chip select three: static, optional NAND
// - Chip selects four, five: static, card
// - External address up to 26 bits
// - Sixteen banks: internal, external, peripherals
// - Unused area answered with abort
module brd_decoder #(
  parameter int MASTERS = brd_pkg::MASTER_N
) (
  input  wire logic                     mclk_i,          // System bus clock
  input  wire logic                     arst_n_i,        // Async reset, low
  input  wire logic                     boot_select_pin_i, // Boot pin level
  input  wire logic                     remap_set_i,     // Remap command pulse
  input  wire logic                     remap_clr_i,     // Remap clear pulse
  input  wire logic                     cs1_sdram_i,     // CS1 to SDRAM ctrl
  input  wire logic                     cs3_nand_i,      // CS3 NAND logic on
  input  wire logic                     cs45_card_i,     // CS4/5 card logic on
  input  wire brd_pkg::brd_req_s [MASTERS-1:0] req_i,    // Master requests
  output brd_pkg::brd_sel_s [MASTERS-1:0] sel_o,         // Decoded selects
  output logic                          remap_o,         // Remap status
  output logic                          boot_pin_q_o,    // Captured boot pin
  output brd_pkg::brd_smc_cfg_s         smc_cfg_o        // Static ctrl defaults
);

  // Elaboration check: the processor lanes and the lane checks need three
  if (MASTERS < 3 || MASTERS > 16) begin : g_bad_masters
    $error("brd_decoder: MASTERS must be 3..16");
  end

  // Pin synchroniser; the first stage feeds only the second
  logic pin_s1_q;
  logic pin_s2_q;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= boot_select_pin_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Capture the pin once after release; later pin changes are ignored.
  // Two edges of sync latency pass before the capture, so the first
  // request is accepted only once the strap is held.
  logic [1:0] cap_cnt_q;
  logic       boot_pin_q;
  logic       ready_q;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cap_cnt_q  <= 2'h0;
      boot_pin_q <= 1'b0;
      ready_q    <= 1'b0;
    end else if (!ready_q) begin
      cap_cnt_q <= cap_cnt_q + 2'h1;
      if (cap_cnt_q == brd_pkg::PIN_CAP_CNT) begin
        boot_pin_q <= pin_s2_q;
        ready_q    <= 1'b1;
      end
    end
  end

  // Remap control; reset clears it, set wins over clear
  logic remap_q;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      remap_q <= 1'b0;
    end else if (remap_set_i) begin
      remap_q <= 1'b1;
    end else if (remap_clr_i) begin
      remap_q <= 1'b0;
    end
  end

  // Boot-region slave for the processor masters
  function automatic brd_pkg::brd_slave_e boot_slave(input logic remap,
                                                      input logic pin);
    if (remap) begin
      boot_slave = brd_pkg::SLV_FIRST_INTERNAL_SRAM;
    end else if (pin) begin
      boot_slave = brd_pkg::SLV_ROM;
    end else begin
      boot_slave = brd_pkg::SLV_EXT;
    end
  endfunction

  // Chip select controller role
  function automatic brd_pkg::brd_csctl_e cs_role(input logic [2:0] cs,
                                                   input logic sd,
                                                   input logic nand_on,
                                                   input logic card_on);
    cs_role = brd_pkg::CSC_STATIC;
    if (cs == brd_pkg::CS_ONE && sd) begin
      cs_role = brd_pkg::CSC_SDRAM;
    end else if (cs == brd_pkg::CS_THREE && nand_on) begin
      cs_role = brd_pkg::CSC_NAND;
    end else if ((cs == brd_pkg::CS_FOUR || cs == brd_pkg::CS_FIVE)
                 && card_on) begin
      cs_role = brd_pkg::CSC_CARD;
    end
  endfunction

  // One combinational decode per master, same map except the boot area, three-way for the CPU masters only
  brd_pkg::brd_sel_s [MASTERS-1:0] dec_d;
  brd_pkg::brd_sel_s [MASTERS-1:0] sel_q;

  always_comb begin
    logic [3:0]  bank;
    logic [7:0]  area;
    logic        cpu;
    bank = 4'h0;
    area = 8'h00;
    cpu  = 1'b0;
    for (int m = 0; m < MASTERS; m++) begin
      bank = req_i[m].addr[brd_pkg::BANK_MSB:brd_pkg::BANK_LSB];
      area = req_i[m].addr[brd_pkg::AREA_MSB:brd_pkg::AREA_LSB];
      cpu  = (m == brd_pkg::CPU_INSN) || (m == brd_pkg::CPU_DATA);
      dec_d[m].valid      = req_i[m].valid && ready_q;
      dec_d[m].slave      = brd_pkg::SLV_ABORT;
      dec_d[m].local_addr = req_i[m].addr;
      dec_d[m].cs         = brd_pkg::CS_ZERO;
      dec_d[m].csctl      = brd_pkg::CSC_STATIC;
      dec_d[m].ext_addr   = req_i[m].addr[brd_pkg::EXT_ADDR_W-1:0];
      dec_d[m].abort      = 1'b0;
      if (bank == brd_pkg::BANK_INTERNAL) begin
        case (area)
          brd_pkg::AREA_BOOT: begin
            if (cpu) begin
              dec_d[m].slave = boot_slave(remap_q, boot_pin_q);
            end else begin
              dec_d[m].slave = remap_q ? brd_pkg::SLV_FIRST_INTERNAL_SRAM
                                       : brd_pkg::SLV_ABORT;
            end
          end
          brd_pkg::AREA_ROM:   dec_d[m].slave = brd_pkg::SLV_ROM;
          brd_pkg::AREA_FIRST_INTERNAL_SRAM: dec_d[m].slave = brd_pkg::SLV_FIRST_INTERNAL_SRAM;
          brd_pkg::AREA_SECOND_INTERNAL_SRAM: dec_d[m].slave = brd_pkg::SLV_SECOND_INTERNAL_SRAM;
          brd_pkg::AREA_USBH:  dec_d[m].slave = brd_pkg::SLV_USBH;
          default:             dec_d[m].slave = brd_pkg::SLV_ABORT;
        endcase
      end else if (bank >= brd_pkg::BANK_EXT_FIRST &&
                   bank <= brd_pkg::BANK_EXT_LAST) begin
        // Bank n maps to chip select n-1, 256 Mbytes each
        dec_d[m].slave = brd_pkg::SLV_EXT;
        dec_d[m].cs    = 3'(bank - brd_pkg::BANK_EXT_FIRST);
      end else if (bank == brd_pkg::BANK_PERIPH) begin
        dec_d[m].slave = brd_pkg::SLV_PERIPH;
      end
      // Boot region on the external path always uses chip select zero
      if (dec_d[m].slave == brd_pkg::SLV_EXT) begin
        dec_d[m].csctl = cs_role(dec_d[m].cs, cs1_sdram_i, cs3_nand_i,
                                 cs45_card_i);
      end
      dec_d[m].abort = dec_d[m].valid &&
                       (dec_d[m].slave == brd_pkg::SLV_ABORT);
    end
  end

  // Registered select outputs, one cycle after the request
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_q <= '0;
    end else begin
      sel_q <= dec_d;
    end
  end

  // Static controller defaults: reset clears them, every edge after release loads them
  brd_pkg::brd_smc_cfg_s smc_q;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      smc_q <= '0;
    end else begin
      smc_q.byte_select  <= 1'b1;
      smc_q.data_width   <= brd_pkg::DBW_16;
      smc_q.strobe_by_cs <= 1'b1;
    end
  end

  assign sel_o        = sel_q;
  assign remap_o      = remap_q;
  assign boot_pin_q_o = boot_pin_q;
  assign smc_cfg_o    = smc_q;

  // Assertions
  property p_remap_sram;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (remap_q && req_i[0].valid && ready_q &&
       req_i[0].addr[31:20] == 12'h000)
      |=> sel_o[0].slave == brd_pkg::SLV_FIRST_INTERNAL_SRAM;
  endproperty
  a_remap_sram: assert property (p_remap_sram)
    else $error("boot region not FIRST_INTERNAL_SRAM under remap");

  property p_rom_boot;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (!remap_q && boot_pin_q && req_i[1].valid && ready_q &&
       req_i[1].addr[31:20] == 12'h000)
      |=> sel_o[1].slave == brd_pkg::SLV_ROM;
  endproperty
  a_rom_boot: assert property (p_rom_boot)
    else $error("boot region not ROM with pin high");

  property p_ext_boot;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (!remap_q && !boot_pin_q && req_i[0].valid && ready_q &&
       req_i[0].addr[31:20] == 12'h000)
      |=> sel_o[0].slave == brd_pkg::SLV_EXT && sel_o[0].cs == 3'h0;
  endproperty
  a_ext_boot: assert property (p_ext_boot)
    else $error("boot region not chip select zero with pin low");

  property p_pin_held;
    @(posedge mclk_i) disable iff (!arst_n_i)
      ready_q |=> $stable(boot_pin_q);
  endproperty
  a_pin_held: assert property (p_pin_held)
    else $error("captured boot pin changed");

  property p_fixed_second_internal_sram;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (req_i[2].addr[31:20] == 12'h003) |=>
        sel_o[2].slave == brd_pkg::SLV_SECOND_INTERNAL_SRAM;
  endproperty
  a_fixed_second_internal_sram: assert property (p_fixed_second_internal_sram)
    else $error("SECOND_INTERNAL_SRAM not at its fixed base");

  property p_cs_bank;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (req_i[0].addr[31:28] == 4'h3) |=>
        sel_o[0].slave == brd_pkg::SLV_EXT && sel_o[0].cs == 3'h2;
  endproperty
  a_cs_bank: assert property (p_cs_bank)
    else $error("bank 3 not chip select two");

  property p_abort;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (req_i[0].valid && ready_q && req_i[0].addr[31:28] == 4'hA)
      |=> sel_o[0].abort;
  endproperty
  a_abort: assert property (p_abort)
    else $error("unused area not aborted");

  property p_remap_reset;
    @(posedge mclk_i) disable iff (!arst_n_i)
      $rose(arst_n_i) |-> !remap_q;
  endproperty
  a_remap_reset: assert property (p_remap_reset)
    else $error("remap set out of reset");

  // A request held through reset must not leak out before the capture
  property p_not_ready;
    @(posedge mclk_i) disable iff (!arst_n_i)
      !ready_q |=> !sel_o[1].valid;
  endproperty
  a_not_ready: assert property (p_not_ready)
    else $error("request passed before boot pin capture");

  property p_fixed_usbh;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (req_i[MASTERS-1].valid && ready_q &&
       req_i[MASTERS-1].addr[31:20] == 12'h005)
      |=> sel_o[MASTERS-1].slave == brd_pkg::SLV_USBH;
  endproperty
  a_fixed_usbh: assert property (p_fixed_usbh)
    else $error("USB host area not at its fixed base");

  property p_ext_addr;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (req_i[1].valid && ready_q)
      |=> sel_o[1].ext_addr == $past(req_i[1].addr[brd_pkg::EXT_ADDR_W-1:0]);
  endproperty
  a_ext_addr: assert property (p_ext_addr)
    else $error("external address not the low request bits");

  property p_remap_set;
    @(posedge mclk_i) disable iff (!arst_n_i)
      remap_set_i |=> remap_o;
  endproperty
  a_remap_set: assert property (p_remap_set)
    else $error("remap not set after set pulse");

  property p_cs1_role;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (req_i[1].valid && ready_q && req_i[1].addr[31:28] == 4'h2 &&
       cs1_sdram_i) |=> sel_o[1].csctl == brd_pkg::CSC_SDRAM;
  endproperty
  a_cs1_role: assert property (p_cs1_role)
    else $error("chip select one not routed to SDRAM");

  // Defaults must stand once requests are served
  property p_smc_cfg;
    @(posedge mclk_i) disable iff (!arst_n_i)
      ready_q |-> smc_cfg_o.byte_select && smc_cfg_o.strobe_by_cs &&
                  smc_cfg_o.data_width == brd_pkg::DBW_16;
  endproperty
  a_smc_cfg: assert property (p_smc_cfg)
    else $error("static controller defaults lost");

endmodule

`default_nettype wire

// ==== brd_master_model.sv ====
// Bus master model: drives every master's request lane of the decoder
`timescale 1ns/1ps
`default_nettype none

module brd_master_model (
  input  wire logic        cmd_valid_i, // A request is wanted
  input  wire logic [2:0]  cmd_m_i,     // Master that asks
  input  wire logic [31:0] cmd_addr_i,  // Request address
  output var  brd_pkg::brd_req_s [brd_pkg::MASTER_N-1:0] req_o // Lanes
);
  // Each master owns its lane; idle lanes carry an inverted address so a
  // decoder that looks at the address without valid gets caught
  always_comb begin
    for (int i = 0; i < brd_pkg::MASTER_N; i++) begin
      req_o[i].valid = cmd_valid_i && (cmd_m_i == i[2:0]);
      req_o[i].addr  = req_o[i].valid ? cmd_addr_i : ~cmd_addr_i;
    end
  end
endmodule

`default_nettype wire

// ==== brd_tb.sv ====
// Testbench: random and corner requests against the boot remap decoder
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t got %h exp %h", $time, (g), (e)); end end

module tb;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic pin = 1'b1, rset = 1'b0, rclr = 1'b0;
  logic sd = 1'b0, nd = 1'b0, cd = 1'b0, cv = 1'b0;
  logic [2:0] cm = 3'h0;
  logic [31:0] ca = 32'h0;
  logic rmp = 1'b0, pin_e = 1'b1, remap, bpq;
  brd_pkg::brd_req_s [5:0] req;
  brd_pkg::brd_sel_s [5:0] sel;
  brd_pkg::brd_smc_cfg_s cfg;
  brd_pkg::brd_sel_s eq[$];
  int mq[$];
  int failures = 0, total_checks = 0;

  // Free-running system clock, 100 ns period
  always #50 mclk_i = ~mclk_i;

  brd_master_model mst_u (.cmd_valid_i(cv), .cmd_m_i(cm), .cmd_addr_i(ca),
    .req_o(req));
  brd_decoder dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .boot_select_pin_i(pin), .remap_set_i(rset), .remap_clr_i(rclr),
    .cs1_sdram_i(sd), .cs3_nand_i(nd), .cs45_card_i(cd), .req_i(req),
    .sel_o(sel), .remap_o(remap), .boot_pin_q_o(bpq), .smc_cfg_o(cfg));

  // Expected decode, worked out from the address map alone
  function automatic brd_pkg::brd_sel_s exp_f(int m, logic [31:0] a);
    brd_pkg::brd_sel_s e;
    e = '0;
    e.valid = 1'b1;
    e.slave = brd_pkg::SLV_ABORT;
    if (a[31:28] == 4'h0) begin
      case (a[27:20])
        8'h00: e.slave = rmp ? brd_pkg::SLV_FIRST_INTERNAL_SRAM : (m > 1 ?
          brd_pkg::SLV_ABORT : pin_e ? brd_pkg::SLV_ROM : brd_pkg::SLV_EXT);
        8'h01: e.slave = brd_pkg::SLV_ROM;
        8'h02: e.slave = brd_pkg::SLV_FIRST_INTERNAL_SRAM;
        8'h03: e.slave = brd_pkg::SLV_SECOND_INTERNAL_SRAM;
        8'h05: e.slave = brd_pkg::SLV_USBH;
        default: e.slave = brd_pkg::SLV_ABORT;
      endcase
    end else if (a[31:28] <= 4'h8) begin
      e.slave = brd_pkg::SLV_EXT;
      e.cs = a[30:28] - 3'h1;
    end else if (a[31:28] == 4'hF) begin
      e.slave = brd_pkg::SLV_PERIPH;
    end
    e.ext_addr = a[25:0];
    e.local_addr = a;
    e.csctl = brd_pkg::CSC_STATIC;
    if (e.cs == 3'h1 && sd) e.csctl = brd_pkg::CSC_SDRAM;
    if (e.cs == 3'h3 && nd) e.csctl = brd_pkg::CSC_NAND;
    if ((e.cs == 3'h4 || e.cs == 3'h5) && cd) e.csctl = brd_pkg::CSC_CARD;
    e.abort = (e.slave == brd_pkg::SLV_ABORT);
    return e;
  endfunction

  // One request per cycle, the expectation queued with it
  task automatic send(int m, logic [31:0] a);
    @(negedge mclk_i);
    cv = 1'b1;
    cm = m[2:0];
    ca = a;
    eq.push_back(exp_f(m, a));
    mq.push_back(m);
  endtask

  // Random address over internal areas, chip selects, peripherals, holes
  function automatic logic [31:0] rnd_a();
    logic [31:0] a;
    logic [7:0] ar [6];
    ar = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h04};
    a = $urandom;
    case ($urandom % 4)
      0: a = {4'h0, ar[$urandom % 6], 6'h00, a[13:0]};
      1: a[31:28] = 4'h1 + 4'($urandom % 8);
      2: a[31:28] = 4'hF;
      default: a[31:28] = 4'h9 + 4'($urandom % 6);
    endcase
    return a;
  endfunction

  // Boot fetch, boot region edge, fixed areas, then random traffic
  task automatic burst(int n);
    {sd, nd, cd} = 3'($urandom);
    send(0, 32'h0);
    send(1, 32'h000F_FFFC);
    send(2, 32'h0);
    send(5, 32'h0010_0000);
    send(2, 32'h0030_0000);
    send(5, 32'h0050_0000);
    send(1, 32'h2000_0000);
    send(0, 32'hA000_0000);
    for (int i = 0; i < n; i++) send($urandom % 6, rnd_a());
    @(negedge mclk_i);
    cv = 1'b0;
    repeat (3) @(negedge mclk_i);
    `CHK(eq.size(), 0)
  endtask

  // Reset for two cycles with the boot pin at p; a request held through
  // reset and the capture edges must never come out as a select
  task automatic rst(logic p);
    @(negedge mclk_i);
    arst_n_i = 1'b0;
    pin = p;
    pin_e = p;
    rmp = 1'b0;
    cv = 1'b1;
    cm = 3'h1;
    ca = 32'h0;
    repeat (2) @(negedge mclk_i);
    arst_n_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    cv = 1'b0;
    `CHK(remap, 1'b0)
    `CHK(bpq, p)
    `CHK(cfg, {1'b1, brd_pkg::DBW_16, 1'b1})
  endtask

  // Pulse the remap controls for one cycle and check the status
  task automatic pulse(logic s, logic c, logic r);
    @(negedge mclk_i);
    rset = s;
    rclr = c;
    @(negedge mclk_i);
    rset = 1'b0;
    rclr = 1'b0;
    rmp = r;
    @(negedge mclk_i);
    `CHK(remap, r)
  endtask

  // Monitor: every valid select is matched against the oldest note
  always @(negedge mclk_i) begin
    brd_pkg::brd_sel_s e;
    int em;
    for (int m = 0; m < 6; m++) begin
      if (sel[m].valid === 1'b1) begin
        if (mq.size() == 0) begin
          `CHK(sel[m].valid, 1'b0)
        end else begin
          e = eq.pop_front();
          em = mq.pop_front();
          `CHK(m, em)
          `CHK(sel[m].slave, e.slave)
          `CHK(sel[m].local_addr, e.local_addr)
          `CHK(sel[m].abort, e.abort)
          if (e.slave == brd_pkg::SLV_EXT) begin
            `CHK(sel[m].cs, e.cs)
            `CHK(sel[m].ext_addr, e.ext_addr)
            `CHK(sel[m].csctl, e.csctl)
          end
        end
      end
    end
  end

  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    failures++;
    end_sim();
  end

  initial begin
    ca = $urandom(32'hF752);
    rst(1'b1);
    burst(40);
    pin = 1'b0; // Late pin change must not move the boot memory
    burst(20);
    pulse(1'b1, 1'b0, 1'b1);
    burst(40);
    rst(1'b0);
    burst(40);
    // Software takes no clock steps here, so chip select zero keeps the
    // slow-boot defaults until it would retune them after the PLL
    `CHK(cfg, {1'b1, brd_pkg::DBW_16, 1'b1})
    pulse(1'b1, 1'b1, 1'b1);
    pulse(1'b0, 1'b1, 1'b0);
    burst(20);
    end_sim();
  end
endmodule

`default_nettype wire
